/* src/rbist_pkg.sv */
// Constants, phase codes and register map of the RAM self-test engine
package rbist_pkg;

  // Register addresses
  localparam logic [15:0] CTRL_ADDR    = 16'h8070;
  localparam logic [15:0] FAIL_LO_ADDR = 16'h8071;
  localparam logic [15:0] FAIL_HI_ADDR = 16'h8072;

  // Control register field positions
  localparam int unsigned FORCE_BIT = 7;
  localparam int unsigned SEL_LSB   = 4;
  localparam int unsigned START_BIT = 3;
  localparam int unsigned FAIL_BIT  = 1;
  localparam int unsigned PASS_BIT  = 0;

  // Operating mode in which the control register accepts writes
  localparam logic [2:0] TEST_MODE = 3'h4;

  // Test select codes
  localparam logic [2:0] SEL_IDLE0   = 3'h0;
  localparam logic [2:0] SEL_PATTERN = 3'h1;
  localparam logic [2:0] SEL_FILL0   = 3'h2;
  localparam logic [2:0] SEL_READ0   = 3'h3;
  localparam logic [2:0] SEL_FILL1   = 3'h4;
  localparam logic [2:0] SEL_READ1   = 3'h5;
  localparam logic [2:0] SEL_INCDEC  = 3'h6;
  localparam logic [2:0] SEL_IDLE7   = 3'h7;

  // Last four-byte group (byte address 0x7ffc) and last march step
  localparam logic [12:0] GRP_LAST   = 13'h1fff;
  localparam logic [3:0]  MARCH_LAST = 4'h9;

  // Values after reset
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [14:0] FAIL_RST = 15'h0000;

  // Background bytes and march patterns, steps 1 to 8
  localparam logic [7:0] BG_ZERO = 8'h00;
  localparam logic [7:0] BG_ONES = 8'hff;
  localparam logic [7:0] MARCH_PAT [0:7] = '{8'h55, 8'haa, 8'h33, 8'hcc,
                                            8'h0f, 8'hf0, 8'h00, 8'hff};

  typedef enum logic [3:0] {
    PH_IDLE   = 4'h0,
    PH_FILL   = 4'h1,
    PH_SWEEP  = 4'h2,
    PH_MARCH  = 4'h3,
    PH_INC_WR = 4'h4,
    PH_INC_RD = 4'h5,
    PH_CMP    = 4'h6,
    PH_CMP_RD = 4'h7
  } rbist_phase_e;

  typedef enum logic [1:0] {
    SUB_WR   = 2'h0,
    SUB_RD   = 2'h1,
    SUB_WAIT = 2'h2,
    SUB_CHK  = 2'h3
  } rbist_sub_e;

endpackage

/* src/rbist_pattern.sv */
// Write data and expected data for each phase and step of the test
`timescale 1ns/10ps
module rbist_pattern (
  input  wire rbist_pkg::rbist_phase_e phase_in,
  input  wire logic [3:0]              step_in,
  input  wire logic                    bg_in,
  input  wire logic [12:0]             grp_in,
  output logic [31:0]                  wr_data_out,
  output logic [31:0]                  exp_data_out,
  output logic                         has_wr_out,
  output logic                         has_rd_out
);
  logic [7:0]  bg_byte;
  logic [31:0] inc_word;
  logic [7:0]  pat;

  // Incrementing value: low eight bits of each byte address
  for (genvar l = 0; l < 4; l++) begin : g_inc
    assign inc_word[8*l +: 8] = {grp_in[5:0], 2'(l)};
  end

  assign bg_byte = bg_in ? rbist_pkg::BG_ONES : rbist_pkg::BG_ZERO;
  assign pat     = rbist_pkg::MARCH_PAT[3'(step_in - 4'h1)];

  // Operation table
  always_comb begin
    wr_data_out  = 32'h0;
    exp_data_out = 32'h0;
    has_wr_out   = 1'b0;
    has_rd_out   = 1'b0;
    case (phase_in)
      rbist_pkg::PH_FILL: begin
        wr_data_out = {4{bg_byte}};
        has_wr_out  = 1'b1;
      end
      rbist_pkg::PH_SWEEP: begin
        exp_data_out = {4{bg_byte}};
        has_rd_out   = 1'b1;
      end
      rbist_pkg::PH_MARCH: begin
        if (step_in == 4'h0) begin
          exp_data_out = {4{bg_byte}};
          has_rd_out   = 1'b1;
        end else if (step_in == rbist_pkg::MARCH_LAST) begin
          wr_data_out = {4{bg_byte}};
          has_wr_out  = 1'b1;
        end else begin
          wr_data_out  = {4{pat}};
          exp_data_out = {4{pat}};
          has_wr_out   = 1'b1;
          has_rd_out   = 1'b1;
        end
      end
      rbist_pkg::PH_INC_WR: begin
        wr_data_out = inc_word;
        has_wr_out  = 1'b1;
      end
      rbist_pkg::PH_INC_RD: begin
        exp_data_out = inc_word;
        has_rd_out   = 1'b1;
      end
      rbist_pkg::PH_CMP: begin
        has_wr_out = 1'b1;
        has_rd_out = 1'b1;
      end
      rbist_pkg::PH_CMP_RD: begin
        exp_data_out = ~inc_word;
        has_rd_out   = 1'b1;
      end
      default: begin
        has_wr_out = 1'b0;
      end
    endcase
  end
endmodule

/* src/rbist_check.sv */
// Per-lane compare of a four-byte read against its expected value
`timescale 1ns/10ps
module rbist_check (
  input  wire logic [31:0] rdata_in,
  input  wire logic [31:0] exp_in,
  input  wire logic        force_in,
  output logic             mismatch_out
);
  logic [3:0] lane_bad;

  // One compare per byte lane
  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign lane_bad[l] = rdata_in[8*l +: 8] != exp_in[8*l +: 8];
  end

  assign mismatch_out = (|lane_bad) | force_in;
endmodule

/* src/rbist_engine.sv */
// RAM self-test engine with its control, status and fail-address registers
`timescale 1ns/10ps
module rbist_engine (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [2:0]  operating_mode_field_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  output logic [12:0]      ram_addr_out,
  output logic             ram_we_out,
  output logic [31:0]      ram_wdata_out,
  input  wire logic [31:0] ram_rdata_in,
  output logic             ram_busy_out,
  output logic             memory_check_fault_out
);
  typedef struct packed {
    logic                    force_fail;
    logic [2:0]              sel;
    logic                    launch;
    logic                    failed;
    logic                    passed;
    logic [14:0]             fail_addr;
    rbist_pkg::rbist_phase_e phase;
    rbist_pkg::rbist_sub_e   sub;
    logic [3:0]              step;
    logic [12:0]             grp;
    logic                    bg;
    logic                    full;
    logic [31:0]             hold;
    logic [12:0]             ram_addr;
    logic                    ram_we;
    logic [31:0]             ram_wdata;
    logic [7:0]              rdata;
    logic                    fault;
  } rbist_state_s;

  rbist_state_s q;
  rbist_state_s d;

  logic [31:0] wr_data;
  logic [31:0] exp_data;
  logic        has_wr;
  logic        has_rd;
  logic        mismatch;
  logic        wr_ctrl;
  logic        wr_allowed;
  logic [7:0]  ctrl_view;

  // Operation of the current phase and step
  rbist_pattern u_pattern (
    .phase_in     (q.phase),
    .step_in      (q.step),
    .bg_in        (q.bg),
    .grp_in       (q.grp),
    .wr_data_out  (wr_data),
    .exp_data_out (exp_data),
    .has_wr_out   (has_wr),
    .has_rd_out   (has_rd)
  );

  // Four lanes compared at once; force bit spoils the first check
  rbist_check u_check (
    .rdata_in     (ram_rdata_in),
    .exp_in       (exp_data),
    .force_in     (q.force_fail),
    .mismatch_out (mismatch)
  );

  // Register decode
  assign wr_ctrl    = reg_wr_in && (reg_addr_in == rbist_pkg::CTRL_ADDR);
  assign wr_allowed = wr_ctrl && (operating_mode_field_in == rbist_pkg::TEST_MODE);
  assign ctrl_view  = {q.force_fail, q.sel, q.launch, 1'b0, q.failed, q.passed};

  // First sub-step of a phase: fills and the incrementing write phase write first, everything else reads first
  function automatic rbist_pkg::rbist_sub_e first_sub(input rbist_pkg::rbist_phase_e ph);
    first_sub = (ph == rbist_pkg::PH_FILL || ph == rbist_pkg::PH_INC_WR) ?
                rbist_pkg::SUB_WR : rbist_pkg::SUB_RD;
  endfunction

  // Next state: register access, then the test sequencer
  always_comb begin
    rbist_pkg::rbist_phase_e start_ph;
    rbist_pkg::rbist_phase_e next_ph;
    logic                    adv;
    logic                    done;
    start_ph = rbist_pkg::PH_IDLE;
    next_ph  = rbist_pkg::PH_IDLE;
    adv      = 1'b0;
    done     = 1'b0;
    d        = q;
    d.ram_we = 1'b0;
    d.fault  = 1'b0;

    // Read data, unmapped addresses read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        rbist_pkg::CTRL_ADDR:    d.rdata = ctrl_view;
        rbist_pkg::FAIL_LO_ADDR: d.rdata = q.fail_addr[7:0];
        rbist_pkg::FAIL_HI_ADDR: d.rdata = {1'b0, q.fail_addr[14:8]};
        default:                 d.rdata = 8'h00;
      endcase
    end

    // Control write: bits 1:0 never written, all ignored outside test mode
    if (wr_allowed && !q.launch) begin
      d.force_fail = reg_wdata_in[rbist_pkg::FORCE_BIT];
      d.sel        = reg_wdata_in[rbist_pkg::SEL_LSB +: 3];
      if (reg_wdata_in[rbist_pkg::START_BIT]) begin
        d.failed    = 1'b0;
        d.passed    = 1'b0;
        d.fail_addr = rbist_pkg::FAIL_RST;
        case (reg_wdata_in[rbist_pkg::SEL_LSB +: 3])
          rbist_pkg::SEL_PATTERN: start_ph = rbist_pkg::PH_FILL;
          rbist_pkg::SEL_FILL0:   start_ph = rbist_pkg::PH_FILL;
          rbist_pkg::SEL_FILL1:   start_ph = rbist_pkg::PH_FILL;
          rbist_pkg::SEL_READ0:   start_ph = rbist_pkg::PH_SWEEP;
          rbist_pkg::SEL_READ1:   start_ph = rbist_pkg::PH_SWEEP;
          rbist_pkg::SEL_INCDEC:  start_ph = rbist_pkg::PH_INC_WR;
          default:                start_ph = rbist_pkg::PH_IDLE;
        endcase
        d.launch = (start_ph != rbist_pkg::PH_IDLE);
        d.phase  = start_ph;
        d.sub    = first_sub(start_ph);
        d.step   = 4'h0;
        d.grp    = 13'h0000;
        d.full   = reg_wdata_in[rbist_pkg::SEL_LSB +: 3] == rbist_pkg::SEL_PATTERN;
        d.bg     = (reg_wdata_in[rbist_pkg::SEL_LSB +: 3] == rbist_pkg::SEL_FILL1) ||
                   (reg_wdata_in[rbist_pkg::SEL_LSB +: 3] == rbist_pkg::SEL_READ1);
      end
    end else if (q.launch) begin
      // One group of four bytes per access; prior RAM contents are lost except in the read-back tests
      case (q.sub)
        rbist_pkg::SUB_WR: begin
          d.ram_addr  = q.grp;
          d.ram_we    = 1'b1;
          d.ram_wdata = (q.phase == rbist_pkg::PH_CMP) ? ~q.hold : wr_data;
          if (has_rd && q.phase != rbist_pkg::PH_CMP) begin
            d.sub = rbist_pkg::SUB_RD;
          end else begin
            adv = 1'b1;
          end
        end
        rbist_pkg::SUB_RD: begin
          d.ram_addr = q.grp;
          d.sub      = rbist_pkg::SUB_WAIT;
        end
        rbist_pkg::SUB_WAIT: begin
          d.sub = rbist_pkg::SUB_CHK;
        end
        rbist_pkg::SUB_CHK: begin
          if (q.phase == rbist_pkg::PH_CMP) begin
            d.hold = ram_rdata_in;
            d.sub  = rbist_pkg::SUB_WR;
          end else if (mismatch) begin
            // Stop at the first bad group and keep its base address
            d.failed    = 1'b1;
            d.fail_addr = {q.grp, 2'b00};
            d.fault     = 1'b1;
            d.launch    = 1'b0;
            d.phase     = rbist_pkg::PH_IDLE;
          end else begin
            adv = 1'b1;
          end
        end
        default: begin
          d.sub = rbist_pkg::SUB_WR;
        end
      endcase

      // Move to the next step, group or phase
      if (adv) begin
        if (q.phase == rbist_pkg::PH_MARCH && q.step != rbist_pkg::MARCH_LAST) begin
          d.step = q.step + 4'h1;
          d.sub  = rbist_pkg::SUB_WR;
        end else if (q.grp != rbist_pkg::GRP_LAST) begin
          d.grp  = q.grp + 13'h0001;
          d.step = 4'h0;
          d.sub  = first_sub(q.phase);
        end else begin
          d.grp  = 13'h0000;
          d.step = 4'h0;
          case (q.phase)
            rbist_pkg::PH_FILL: begin
              next_ph = q.full ? rbist_pkg::PH_MARCH : rbist_pkg::PH_IDLE;
            end
            rbist_pkg::PH_MARCH: begin
              if (q.bg) begin
                next_ph = rbist_pkg::PH_INC_WR;
              end else begin
                next_ph = rbist_pkg::PH_FILL;
                d.bg    = 1'b1;
              end
            end
            rbist_pkg::PH_INC_WR: next_ph = rbist_pkg::PH_INC_RD;
            rbist_pkg::PH_INC_RD: next_ph = rbist_pkg::PH_CMP;
            rbist_pkg::PH_CMP:    next_ph = rbist_pkg::PH_CMP_RD;
            default:              next_ph = rbist_pkg::PH_IDLE;
          endcase
          d.phase = next_ph;
          d.sub   = first_sub(next_ph);
          done    = (next_ph == rbist_pkg::PH_IDLE);
        end
      end

      // Completion: start clears, force turns a clean run into a failure
      if (done) begin
        d.launch = 1'b0;
        if (q.force_fail) begin
          d.failed    = 1'b1;
          d.fail_addr = {rbist_pkg::GRP_LAST, 2'b00};
          d.fault     = 1'b1;
        end else begin
          d.passed = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out          = q.rdata;
  assign ram_addr_out           = q.ram_addr;
  assign ram_we_out             = q.ram_we;
  assign ram_wdata_out          = q.ram_wdata;
  assign ram_busy_out           = q.launch;
  assign memory_check_fault_out = q.fault;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  // Writes outside test mode leave the control fields alone
  property p_write_lock;
    wr_ctrl && operating_mode_field_in != rbist_pkg::TEST_MODE |=>
      $stable(q.sel) && $stable(q.force_fail) && !$rose(q.launch);
  endproperty
  a_write_lock: assert property (p_write_lock) else $error("control written outside mode");

  // A real test code launches and clears the result bits
  property p_launch;
    wr_allowed && !ram_busy_out && reg_wdata_in[3] &&
      reg_wdata_in[6:4] != 3'h0 && reg_wdata_in[6:4] != 3'h7 |=>
      ram_busy_out && !q.failed && !q.passed;
  endproperty
  a_launch: assert property (p_launch) else $error("start did not launch the test");

  // Idle codes touch no RAM
  property p_idle_code;
    wr_allowed && !ram_busy_out && reg_wdata_in[3] &&
      (reg_wdata_in[6:4] == 3'h0 || reg_wdata_in[6:4] == 3'h7) |=>
      (!ram_busy_out && !ram_we_out) [*4];
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("idle code caused RAM activity");

  // A failure pulses the fault event and ends the run together
  property p_fault_pulse;
    $rose(q.failed) |-> memory_check_fault_out && !ram_busy_out ##1 !memory_check_fault_out;
  endproperty
  a_fault_pulse: assert property (p_fault_pulse) else $error("fault event not paired with fail");

  // Only the running engine writes the RAM
  property p_we_busy;
    ram_we_out |-> $past(ram_busy_out);
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("RAM written while not running");

  // Fail address holds while idle
  property p_hold_addr;
    q.failed && !ram_busy_out && !wr_allowed |=> $stable(q.fail_addr);
  endproperty
  a_hold_addr: assert property (p_hold_addr) else $error("fail address changed while idle");

  // A forced run never passes
  property p_force;
    $rose(q.passed) |-> !q.force_fail && !q.failed;
  endproperty
  a_force: assert property (p_force) else $error("pass reported with force set");

  // Zero-background fills write zero
  property p_fill_zero;
    ram_we_out && $past(q.phase) == rbist_pkg::PH_FILL && !$past(q.bg) |->
      ram_wdata_out == 32'h0;
  endproperty
  a_fill_zero: assert property (p_fill_zero) else $error("zero fill wrote nonzero data");

  // First march pattern is 0x55 in all lanes
  property p_march_first;
    ram_we_out && $past(q.phase) == rbist_pkg::PH_MARCH && $past(q.step) == 4'h1 |->
      ram_wdata_out == {4{8'h55}};
  endproperty
  a_march_first: assert property (p_march_first) else $error("march step 1 wrote wrong data");

  // A finished run reports exactly one result
  property p_one_result;
    $fell(ram_busy_out) |-> q.passed != q.failed;
  endproperty
  a_one_result: assert property (p_one_result) else $error("run ended without one result");

  // Recorded fail address is the base of a four-byte group
  property p_fail_group;
    $rose(q.failed) |-> q.fail_addr[1:0] == 2'b00;
  endproperty
  a_fail_group: assert property (p_fail_group) else $error("fail address not group aligned");

  // Ones-background fills write all-ones
  property p_fill_ones;
    ram_we_out && $past(q.phase) == rbist_pkg::PH_FILL && $past(q.bg) |->
      ram_wdata_out == 32'hffff_ffff;
  endproperty
  a_fill_ones: assert property (p_fill_ones) else $error("ones fill wrote wrong data");

  // Incrementing pattern: lane 0 holds the low byte of its own address
  property p_inc_data;
    ram_we_out && $past(q.phase) == rbist_pkg::PH_INC_WR |->
      ram_wdata_out[7:0] == {ram_addr_out[5:0], 2'b00};
  endproperty
  a_inc_data: assert property (p_inc_data) else $error("incrementing value wrong");

  // Complement phase writes back the inverse of the word it read
  property p_cmp_write;
    ram_we_out && $past(q.phase) == rbist_pkg::PH_CMP |->
      ram_wdata_out == ~$past(ram_rdata_in, 2);
  endproperty
  a_cmp_write: assert property (p_cmp_write) else $error("complement write wrong");

  // Upper fail-address byte keeps its top bit clear
  property p_fail_hi;
    reg_rd_in && reg_addr_in == rbist_pkg::FAIL_HI_ADDR |=> !reg_rdata_out[7];
  endproperty
  a_fail_hi: assert property (p_fail_hi) else $error("fail address high bit 7 set");

endmodule

/* bench/rbist_ram_model.sv */
// Behavioural 8192 x 32 synchronous RAM standing behind the self-test engine
`timescale 1ns/10ps
module rbist_ram_model (
  input  wire logic        clk_in,
  input  wire logic [12:0] addr_in,
  input  wire logic        we_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        flt_en_in,
  input  wire logic [12:0] flt_grp_in,
  output logic [31:0]      rdata_out
);
  logic [31:0] mem [0:8191];

  // Stale contents before any test, so a fill that skips a word shows up
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 32'ha5c3_5a3c;
    end
    rdata_out = 32'h0000_0000;
  end

  // One-cycle read latency from the registered address; optional bit flip
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in] ^ ((flt_en_in && addr_in == flt_grp_in) ? 32'h0000_0001
                                                                      : 32'h0000_0000);
  end
endmodule

/* bench/test_ram_builtin_self_test.sv */
// Self-checking testbench of the RAM self-test engine with a RAM model
`timescale 1ns/10ps
module test_ram_builtin_self_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  mode = 3'h4;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [12:0] ram_addr;
  logic        ram_we;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;
  logic        busy;
  logic        fault;
  logic        flt_en = 1'b0;
  logic [12:0] flt_grp = 13'h0000;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          we_cnt = 0;
  int          flt_cnt = 0;
  logic [31:0] q0 [$];

  rbist_engine u_dut (
    .core_clk_in(clk), .rst_in(rst), .operating_mode_field_in(mode),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .ram_addr_out(ram_addr), .ram_we_out(ram_we),
    .ram_wdata_out(ram_wdata), .ram_rdata_in(ram_rdata), .ram_busy_out(busy),
    .memory_check_fault_out(fault)
  );

  rbist_ram_model u_ram (
    .clk_in(clk), .addr_in(ram_addr), .we_in(ram_we), .wdata_in(ram_wdata),
    .flt_en_in(flt_en), .flt_grp_in(flt_grp), .rdata_out(ram_rdata)
  );

  // Clock and cycle ceiling against a hung test
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      $display("[ERR] %0t ns: cycle ceiling reached", $time);
      test_done();
    end
  end

  // Count RAM writes and fault pulses mid-cycle; log every write to group 0
  always @(negedge clk) begin
    if (ram_we === 1'b1) we_cnt++;
    if (fault === 1'b1) flt_cnt++;
    if (ram_we === 1'b1 && ram_addr === 13'h0000) q0.push_back(ram_wdata);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rdata, exp);
  endtask

  // Start a test and wait for the engine to drop busy
  task automatic run(input logic [7:0] v);
    int n;
    n = 0;
    q0.delete();
    wreg(rbist_pkg::CTRL_ADDR, v);
    chk(busy, 1'b1);
    while (busy === 1'b1 && n < 40000) begin
      @(posedge clk);
      #1 n++;
    end
    #1 chk(busy, 1'b0);
  endtask

  task automatic failaddr(input logic [7:0] lo, input logic [7:0] hi);
    rdc(rbist_pkg::FAIL_LO_ADDR, lo);
    rdc(rbist_pkg::FAIL_HI_ADDR, hi);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    int w;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    // Reset values and read-only places
    rdc(rbist_pkg::CTRL_ADDR, 8'h00);
    failaddr(8'h00, 8'h00);
    wreg(rbist_pkg::FAIL_LO_ADDR, 8'h55);
    rdc(rbist_pkg::FAIL_LO_ADDR, 8'h00);
    rdc(16'h8073, 8'h00);
    // Writes outside test mode are ignored; status bits cannot be written
    mode = 3'h1;
    wreg(rbist_pkg::CTRL_ADDR, 8'hf0);
    rdc(rbist_pkg::CTRL_ADDR, 8'h00);
    mode = 3'h4;
    wreg(rbist_pkg::CTRL_ADDR, 8'h83);
    rdc(rbist_pkg::CTRL_ADDR, 8'h80);
    // Both idle codes leave the RAM alone
    for (int s = 0; s < 8; s += 7) begin
      w = we_cnt;
      wreg(rbist_pkg::CTRL_ADDR, {1'b0, s[2:0], 4'h8});
      repeat (3) @(posedge clk);
      chk(we_cnt, w);
      rdc(rbist_pkg::CTRL_ADDR, {1'b0, s[2:0], 4'h0});
    end
    // Forced failure on the zero fill: fails at the last group
    run(8'ha8);
    rdc(rbist_pkg::CTRL_ADDR, 8'ha2);
    failaddr(8'hfc, 8'h7f);
    chk(flt_cnt, 1);
    chk(u_ram.mem[0], 32'h0000_0000);
    chk(u_ram.mem[8191], 32'h0000_0000);
    // Zero read-back passes; status cleared at start, writes while busy ignored
    wreg(rbist_pkg::CTRL_ADDR, 8'h38);
    rdc(rbist_pkg::CTRL_ADDR, 8'h38);
    wreg(rbist_pkg::CTRL_ADDR, 8'h00);
    rdc(rbist_pkg::CTRL_ADDR, 8'h38);
    w = 0;
    while (busy === 1'b1 && w < 40000) begin
      @(posedge clk);
      #1 w++;
    end
    rdc(rbist_pkg::CTRL_ADDR, 8'h31);
    failaddr(8'h00, 8'h00);
    // Ones fill, then ones read-back with a bad bit at group 0x40
    run(8'h48);
    rdc(rbist_pkg::CTRL_ADDR, 8'h41);
    chk(u_ram.mem[100], 32'hffff_ffff);
    flt_en = 1'b1;
    flt_grp = 13'h0040;
    run(8'h58);
    rdc(rbist_pkg::CTRL_ADDR, 8'h52);
    failaddr(8'h00, 8'h01);
    // Incrementing test: no background sweep, bad bit at group 3
    flt_grp = 13'h0003;
    run(8'h68);
    rdc(rbist_pkg::CTRL_ADDR, 8'h62);
    failaddr(8'h0c, 8'h00);
    chk(q0.size(), 1);
    chk(q0[0], 32'h0302_0100);
    chk(u_ram.mem[5], 32'h1716_1514);
    chk(u_ram.mem[8191], 32'hfffe_fdfc);
    // Pattern test: zero fill, full march of group 0, failure at group 1
    flt_grp = 13'h0001;
    run(8'h18);
    rdc(rbist_pkg::CTRL_ADDR, 8'h12);
    failaddr(8'h04, 8'h00);
    chk(q0.size(), 10);
    chk(q0[0], 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      chk(q0[i + 1], {4{rbist_pkg::MARCH_PAT[i]}});
    end
    chk(q0[9], 32'h0000_0000);
    chk(flt_cnt, 4);
    test_done();
  end
endmodule
